// >>> rtl/dsp_regfile.sv
// Register storage with soft reset and read index
`timescale 1ns/1ns
`default_nettype none
module dsp_regfile #(
  parameter int unsigned ADDR_W  = dsp_pkg::LEG_ADDR_W,
  parameter logic [23:0] CHIP_ID = 24'h0a5a5a  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  // Write port
  input  wire dsp_pkg::dsp_wr_t   i_wr,
  // Read port
  input  wire logic [ADDR_W-1:0]  i_rd_addr,
  output logic      [23:0]        o_rd_data,
  // Open framing read pointer from register zero
  output logic      [4:0]         o_rd_ptr,
  // Soft reset pulse
  output logic                    o_soft_rst
);
  localparam int unsigned N = 2 ** ADDR_W;
  logic [23:0] mem_q [N];
  logic        soft_q;
  logic        soft_d;

  assign soft_d = i_wr.en && (i_wr.addr == dsp_pkg::REG0_ADDR)
                  && i_wr.data[dsp_pkg::SOFT_RST_BIT];

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_reg
      always_ff @(posedge i_clk) begin
        if (!i_rst_b || soft_q) begin
          mem_q[g] <= dsp_pkg::REG_RST_VAL;
        end else if (i_wr.en && (i_wr.addr[ADDR_W-1:0] == ADDR_W'(g))) begin
          mem_q[g] <= i_wr.data;
        end
      end
    end
  endgenerate

  // Register zero reads back the identity value, its write holds the pointer
  assign o_rd_data  = (i_rd_addr == '0) ? CHIP_ID : mem_q[i_rd_addr];
  assign o_rd_ptr   = mem_q[0][dsp_pkg::RD_PTR_LSB +: 5];
  assign o_soft_rst = soft_q;
endmodule // dsp_regfile
`default_nettype wire

// >>> rtl/dsp_serial_port.sv
// Dual framing serial control port: framing decision, legacy and open framing
//
// Operation
// - Framing chosen on first enable or clock activity, kept until hard reset.
// - Enable rising first after reset selects legacy single-target framing.
// - Clock rising first after reset selects addressed multi-target framing.
// - Legacy frame: one read/write bit, six address bits, twenty-four data bits.
// - Data-in low at first clock rise after enable marks a write.
// - Legacy address bits captured MSB first on rising edges 2 to 7.
// - Legacy write data shifted in MSB first on rising edges 8 to 31.
// - Write data committed to addressed register on the 32nd rising edge.
// - Data-in high at first clock rise after enable starts a read.
// - Legacy read captures six address bits on rising edges 2 to 7.
// - Legacy read drives 24 bits MSB first on shared output, edges 8 to 31.
// - Shared output returns to lock indication on the 32nd rising edge.
// - Multi-target frame holds 3-bit chip address and 5-bit register address.
// - Multi-target frame shifts read data out while write data shifts in.
// - Three wires suffice for writes; data-out line adds reads.
// - Serial clock supported up to 50 MHz.
// - Multi-target data and addresses latched only on enable rising edge.
// - Multi-target write acted on only when chip address is all zeros; read data shifts out for any chip address.
// - Multi-target frame outputs register selected by register zero low bits.
// - Soft reset leaves the selected framing unchanged.
`timescale 1ns/1ns
`default_nettype none
module dsp_serial_port #(
  parameter logic [23:0] CHIP_ID = 24'h0a5a5a  // Arbitrary identity value
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // Serial link pins
  input  wire dsp_pkg::dsp_link_t i_link,
  // Lock indication from the loop and driver policy
  input  wire logic          i_lock_indication,
  input  wire logic          i_keep_driver_on,
  // Shared lock or readback pin
  output logic               o_lock_or_readback_out,
  output logic               o_lock_or_readback_out_oe,
  // Framing status
  output logic               o_legacy_single_target_framing,
  output logic               o_open_framing,
  // Register write strobe seen by the rest of the device
  output logic               o_wr_strobe,
  output logic [5:0]         o_wr_addr,
  output logic [23:0]        o_wr_data
);
  localparam int unsigned DW = dsp_pkg::DATA_W;

  // Synchronised link pins and lock input
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  // Pins sampled by the system clock
  // Each serial clock phase must last more than one system clock to be seen
  dsp_sync #(
    .W (4)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_lock_indication, i_link.serial_port_enable, i_link.sclk, i_link.sdi}),
    .o_level (pin_lvl),
    .o_rise  (pin_rise),
    .o_fall  (pin_fall)
  );

  logic sen_lvl;
  logic sen_rise;
  logic sen_fall;
  logic sclk_rise;
  logic sdi_lvl;
  logic lock_lvl;
  assign sdi_lvl   = pin_lvl[0];
  assign sclk_rise = pin_rise[1];
  assign sen_lvl   = pin_lvl[2];
  assign sen_rise  = pin_rise[2];
  assign sen_fall  = pin_fall[2];
  assign lock_lvl  = pin_lvl[3];

  // Framing selection
  dsp_pkg::dsp_mode_t mode_q;
  logic               legacy_now;
  logic               open_now;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mode_q <= dsp_pkg::DSP_MODE_UNDECIDED;
    end else begin
      case (mode_q)
        dsp_pkg::DSP_MODE_UNDECIDED: begin
          if (sen_rise) begin
            mode_q <= dsp_pkg::DSP_MODE_LEGACY;
          end else if (sclk_rise) begin
            mode_q <= dsp_pkg::DSP_MODE_OPEN;
          end
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // The deciding event itself belongs to the chosen framing
  // Same-cycle edges resolve to legacy framing
  assign legacy_now = (mode_q == dsp_pkg::DSP_MODE_LEGACY)
                      || ((mode_q == dsp_pkg::DSP_MODE_UNDECIDED) && sen_rise);
  assign open_now   = (mode_q == dsp_pkg::DSP_MODE_OPEN)
                      || ((mode_q == dsp_pkg::DSP_MODE_UNDECIDED) && !sen_rise && sclk_rise);

  // Register storage
  dsp_pkg::dsp_wr_t wr;
  logic [5:0]       rd_addr;
  logic [23:0]      rd_data;
  logic [4:0]       rd_ptr;

  dsp_regfile #(
    .ADDR_W  (dsp_pkg::LEG_ADDR_W),
    .CHIP_ID (CHIP_ID)
  ) u_regs (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_wr       (wr),
    .i_rd_addr  (rd_addr),
    .o_rd_data  (rd_data),
    .o_rd_ptr   (rd_ptr),
    .o_soft_rst ()
  );

  // Legacy framing
  logic [5:0]    leg_cnt_q;
  logic          leg_rd_q;
  logic [5:0]    leg_addr_q;
  logic [DW-1:0] leg_data_q;
  logic          leg_out_q;
  logic          leg_drive_q;
  logic [5:0]    leg_cnt_d;
  logic [5:0]    leg_addr_full;
  logic          leg_edge;
  logic          leg_commit;

  assign leg_edge      = legacy_now && sen_lvl && sclk_rise;
  assign leg_cnt_d     = leg_cnt_q + 6'h01;
  assign leg_addr_full = {leg_addr_q[4:0], sdi_lvl};
  // Commit on the 32nd edge of a write
  assign leg_commit    = leg_edge && !leg_rd_q && (leg_cnt_d == dsp_pkg::FRAME_EDGES);

  // Edge counter frames the bit fields
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      leg_cnt_q <= '0;
    // Early enable fall abandons the frame
    end else if (legacy_now && (sen_rise || sen_fall)) begin
      leg_cnt_q <= '0;
    end else if (leg_edge && (leg_cnt_q != dsp_pkg::FRAME_EDGES)) begin
      leg_cnt_q <= leg_cnt_d;
    end
  end

  // First edge samples the read flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      leg_rd_q <= 1'b0;
    end else if (leg_edge && (leg_cnt_d == dsp_pkg::LEG_RW_EDGE)) begin
      leg_rd_q <= sdi_lvl;
    end
  end

  // Address shift on edges 2 to 7
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      leg_addr_q <= '0;
    end else if (leg_edge && (leg_cnt_d >= dsp_pkg::LEG_ADDR_FIRST)
                 && (leg_cnt_d <= dsp_pkg::LEG_ADDR_LAST)) begin
      leg_addr_q <= leg_addr_full;
    end
  end

  // Data shift on edges 8 to 31
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      leg_data_q <= '0;
    // Read word loaded on edge 7, ready for edge 8
    end else if (leg_edge && (leg_cnt_d == dsp_pkg::LEG_ADDR_LAST) && leg_rd_q) begin
      leg_data_q <= rd_data;
    end else if (leg_edge && (leg_cnt_d >= dsp_pkg::LEG_DATA_FIRST)
                 && (leg_cnt_d <= dsp_pkg::LEG_DATA_LAST)) begin
      leg_data_q <= {leg_data_q[DW-2:0], sdi_lvl};
    end
  end

  // Read data MSB first on edges 8 to 31
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      leg_out_q   <= 1'b0;
      leg_drive_q <= 1'b0;
    // Any enable edge ends a read
    end else if (!legacy_now || sen_rise || sen_fall) begin
      leg_out_q   <= 1'b0;
      leg_drive_q <= 1'b0;
    end else if (leg_edge && leg_rd_q && (leg_cnt_d >= dsp_pkg::LEG_DATA_FIRST)
                 && (leg_cnt_d <= dsp_pkg::LEG_DATA_LAST)) begin
      leg_out_q   <= leg_data_q[DW-1];
      leg_drive_q <= 1'b1;
    // Lock indication back on edge 32
    end else if (leg_edge && (leg_cnt_d == dsp_pkg::FRAME_EDGES)) begin
      leg_out_q   <= 1'b0;
      leg_drive_q <= 1'b0;
    end
  end

  // Open framing
  logic [31:0]   op_sh_q;
  logic [5:0]    op_cnt_q;
  logic [DW-1:0] op_rd_q;
  logic          op_out_q;
  logic          op_drive_q;
  logic          op_edge;
  logic          op_latch;
  logic          op_first;

  assign op_edge  = open_now && !sen_lvl && sclk_rise;
  assign op_first = op_edge && (op_cnt_q == '0);
  // Write taken from the last 32 bits shifted before enable rose
  // Latch only on enable rise
  // Only chip address zero is acted on
  assign op_latch = (mode_q == dsp_pkg::DSP_MODE_OPEN) && sen_rise
                    && (op_sh_q[dsp_pkg::CHIP_W-1:0] == dsp_pkg::OPEN_CHIP_SELF);

  // 24 data, 5 register and 3 chip bits, MSB first
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      op_sh_q  <= '0;
      op_cnt_q <= '0;
    end else if (sen_rise) begin
      op_cnt_q <= '0;
    end else if (op_edge) begin
      op_sh_q  <= {op_sh_q[30:0], sdi_lvl};
      op_cnt_q <= (op_cnt_q == dsp_pkg::FRAME_EDGES) ? op_cnt_q : op_cnt_d();
    end
  end

  function automatic logic [5:0] op_cnt_d();
    return op_cnt_q + 6'h01;
  endfunction

  // Read shifts out while write shifts in
  // Source is the register named by register zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      op_rd_q    <= '0;
      op_out_q   <= 1'b0;
      op_drive_q <= 1'b0;
    end else if (sen_rise || !open_now) begin
      op_rd_q    <= '0;
      op_out_q   <= 1'b0;
      op_drive_q <= 1'b0;
    // First edge loads the register named by register zero
    end else if (op_first) begin
      op_rd_q    <= {rd_data[DW-2:0], 1'b0};
      op_out_q   <= rd_data[DW-1];
      op_drive_q <= 1'b1;
    end else if (op_edge) begin
      op_rd_q    <= {op_rd_q[DW-2:0], 1'b0};
      op_out_q   <= op_rd_q[DW-1];
    end
  end

  // Shared read index: register zero pointer, or the legacy address with
  // the bit arriving on edge 7 so the load on that edge sees all six bits
  assign rd_addr = open_now ? {1'b0, rd_ptr} : leg_addr_full;

  // Write port to storage
  always_comb begin
    wr.en   = 1'b0;
    wr.addr = '0;
    wr.data = '0;
    if (leg_commit) begin
      wr.en   = 1'b1;
      wr.addr = leg_addr_q;
      wr.data = leg_data_q;
    end else if (op_latch) begin
      wr.en   = 1'b1;
      wr.addr = {1'b0, op_sh_q[7:3]};
      wr.data = op_sh_q[31:8];
    end
  end

  // Registered outputs
  // Read data takes the pin ahead of lock indication
  // Data-out only needed for reads
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_lock_or_readback_out    <= 1'b0;
      o_lock_or_readback_out_oe <= 1'b0;
    end else if (leg_drive_q) begin
      o_lock_or_readback_out    <= leg_out_q;
      o_lock_or_readback_out_oe <= 1'b1;
    end else if (op_drive_q) begin
      o_lock_or_readback_out    <= op_out_q;
      o_lock_or_readback_out_oe <= 1'b1;
    end else begin
      o_lock_or_readback_out    <= lock_lvl;
      o_lock_or_readback_out_oe <= i_keep_driver_on;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_legacy_single_target_framing <= 1'b0;
      o_open_framing                 <= 1'b0;
    end else begin
      o_legacy_single_target_framing <= (mode_q == dsp_pkg::DSP_MODE_LEGACY);
      o_open_framing                 <= (mode_q == dsp_pkg::DSP_MODE_OPEN);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_wr_strobe <= 1'b0;
      o_wr_addr   <= '0;
      o_wr_data   <= '0;
    end else begin
      o_wr_strobe <= wr.en;
      if (wr.en) begin
        o_wr_addr <= wr.addr;
        o_wr_data <= wr.data;
      end
    end
  end
endmodule // dsp_serial_port
`default_nettype wire

// >>> rtl/dsp_sync.sv
// Two flip-flop synchroniser with edge detection, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module dsp_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Asynchronous inputs
  input  wire logic [W-1:0] i_async,
  // Synchronised level and edges
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
          prev_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
      assign o_level[g] = sync_q[g];
      assign o_rise[g]  = sync_q[g] & ~prev_q[g];
      assign o_fall[g]  = ~sync_q[g] & prev_q[g];
    end
  endgenerate
endmodule // dsp_sync
`default_nettype wire

// >>> shared/dsp_pkg.sv
// Shared constants and types for the dual protocol serial port
package dsp_pkg;
  localparam int unsigned DATA_W         = 24;
  localparam int unsigned LEG_ADDR_W     = 6;
  localparam int unsigned OPEN_ADDR_W    = 5;
  localparam int unsigned CHIP_W         = 3;
  localparam int unsigned CNT_W          = 6;
  localparam logic [5:0]  LEG_RW_EDGE    = 6'h01;
  localparam logic [5:0]  LEG_ADDR_FIRST = 6'h02;
  localparam logic [5:0]  LEG_ADDR_LAST  = 6'h07;
  localparam logic [5:0]  LEG_DATA_FIRST = 6'h08;
  localparam logic [5:0]  LEG_DATA_LAST  = 6'h1f;
  localparam logic [5:0]  FRAME_EDGES    = 6'h20;
  localparam int unsigned OPEN_FRAME_W   = 32;
  localparam logic [2:0]  OPEN_CHIP_SELF = 3'h0;
  localparam int unsigned SOFT_RST_BIT   = 5;
  localparam int unsigned RD_PTR_LSB     = 0;
  localparam logic [23:0] REG_RST_VAL    = 24'h000000;
  localparam logic [5:0]  REG0_ADDR      = 6'h00;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned MAX_SCLK_MHZ   = 50;

  typedef enum logic [1:0] {
    DSP_MODE_UNDECIDED,
    DSP_MODE_LEGACY,
    DSP_MODE_OPEN
  } dsp_mode_t;

  typedef struct packed {
    logic serial_port_enable;
    logic sclk;
    logic sdi;
  } dsp_link_t;

  typedef struct packed {
    logic        en;
    logic [5:0]  addr;
    logic [23:0] data;
  } dsp_wr_t;
endpackage

// >>> sim/dsp_host_model.sv
// Host side serial controller model driving the link pins
`timescale 1ns/1ns
`default_nettype none
module dsp_host_model (
  // Link pins
  output var dsp_pkg::dsp_link_t o_link,
  // Shared lock or readback wire
  input  wire logic              i_sdo
);
  initial o_link = '0;
  // one frame, MSB first, 8 MHz clock idle outside
  task automatic frame(input logic leg, input logic [31:0] b, input int n,
                       output logic [23:0] q);
    q = '0;
    // enable edge opens a legacy frame
    o_link.serial_port_enable = leg;
    o_link.sdi = b[31];
    #63;
    for (int k = 1; k <= n; k++) begin
      o_link.sclk = 1'b1;
      #62;
      o_link.sclk = 1'b0;
      // returned bits taken on falling edges
      if (k >= (leg ? 8 : 1) && k < (leg ? 32 : 25))
        q = {q[22:0], i_sdo};
      o_link.sdi = (k < 32) ? b[31-k] : ~o_link.sdi;
      #63;
    end
    // enable moved after the last rising edge
    o_link.serial_port_enable = !leg;
    o_link.sdi = ~o_link.sdi;
    #250;
  endtask
endmodule // dsp_host_model
`default_nettype wire

// >>> sim/dsp_serial_port_properties.sv
// Concurrent checks on the serial port top ports
`timescale 1ns/1ns
`default_nettype none
module dsp_serial_port_properties (
  // Clock, reset and inputs
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  input wire dsp_pkg::dsp_link_t i_link,
  input wire logic               i_lock_indication,
  input wire logic               i_keep_driver_on,
  // Outputs watched
  input wire logic               o_lock_or_readback_out,
  input wire logic               o_lock_or_readback_out_oe,
  input wire logic               o_legacy_single_target_framing,
  input wire logic               o_open_framing,
  input wire logic               o_wr_strobe,
  input wire logic [5:0]         o_wr_addr,
  input wire logic [23:0]        o_wr_data
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic en;
  logic leg;
  logic opn;
  assign en  = i_link.serial_port_enable;
  assign leg = o_legacy_single_target_framing;
  assign opn = o_open_framing;
  sequence s_leg_idle;
    (!en && !i_keep_driver_on)[*8];
  endsequence
  sequence s_lock_quiet;
    (!en && i_keep_driver_on && $stable(i_lock_indication))[*8];
  endsequence
  sequence s_open_idle;
    (en && !i_keep_driver_on)[*8];
  endsequence
  AST_ONE_FRAMING: assert property (!(leg && opn))
    else $error("both framings selected");
  AST_LEG_KEPT: assert property (leg |=> leg)
    else $error("legacy framing dropped");
  AST_OPEN_KEPT: assert property (opn |=> opn)
    else $error("open framing dropped");
  AST_STROBE_ONE: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe longer than one cycle");
  AST_WR_HOLD: assert property (!o_wr_strobe |-> $stable(o_wr_addr) && $stable(o_wr_data))
    else $error("write address or data moved without strobe");
  AST_OPEN_ADDR5: assert property (opn && o_wr_strobe |-> !o_wr_addr[5])
    else $error("open write address beyond five bits");
  AST_OPEN_ON_ENABLE: assert property (opn && o_wr_strobe |-> $past(en, 2))
    else $error("open write without enable rise");
  AST_LEG_IN_FRAME: assert property (leg && o_wr_strobe |-> $past(en, 3))
    else $error("legacy write outside a frame");
  AST_LEG_RELEASE: assert property (leg ##0 s_leg_idle |-> !o_lock_or_readback_out_oe)
    else $error("driver left on after legacy frame");
  AST_LOCK_SHOWN: assert property (leg ##0 s_lock_quiet |->
    o_lock_or_readback_out_oe && o_lock_or_readback_out == i_lock_indication)
    else $error("lock level not shown while idle");
  AST_OPEN_IDLE: assert property (opn ##0 s_open_idle |-> !o_lock_or_readback_out_oe)
    else $error("driver left on after open frame");
endmodule // dsp_serial_port_properties
`default_nettype wire

// >>> sim/test_dual_protocol_serial_port.sv
// Self-checking bench for the dual framing serial port
`timescale 1ns/1ns
`default_nettype none
module test_dual_protocol_serial_port;
  localparam logic [23:0] ID = 24'h0a5a5a;  // Arbitrary identity value
  logic               i_clk;
  logic               i_rst_b;
  dsp_pkg::dsp_link_t link;
  logic               lock;
  logic               keep;
  logic               sdo;
  logic               sdo_oe;
  logic               sdo_w;
  logic               leg;
  logic               opn;
  logic               wr_stb;
  logic [5:0]         wr_addr;
  logic [23:0]        wr_data;
  int                 failures = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  logic [31:0]        rnd;
  logic [23:0]        mem [64];
  logic [4:0]         ptr;
  logic [23:0]        q;
  logic [5:0]         ad [4] = '{6'h3f, 6'h01, 6'h2a, 6'h00};
  logic [29:0]        got_q [$];
  logic [29:0]        exp_q [$];

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  assign sdo_w = sdo_oe ? sdo : 1'bz;

  dsp_serial_port #(.CHIP_ID(ID)) i_dsp_serial_port (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_link(link),
    .i_lock_indication(lock), .i_keep_driver_on(keep),
    .o_lock_or_readback_out(sdo), .o_lock_or_readback_out_oe(sdo_oe),
    .o_legacy_single_target_framing(leg), .o_open_framing(opn),
    .o_wr_strobe(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  dsp_host_model i_dsp_host_model (.o_link(link), .i_sdo(sdo_w));

  // Outputs sampled mid-cycle, clear of the launching edge
  always @(negedge i_clk) begin
    cycles <= cycles + 1;
    if (wr_stb === 1'b1) got_q.push_back({wr_addr, wr_data});
    if (cycles == 30000) begin
      failures++;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] mread(input logic [5:0] a);
    return (a == 6'h00) ? ID : mem[a];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic mwrite(input logic [5:0] a, input logic [23:0] d);
    exp_q.push_back({a, d});
    if (a != 6'h00) mem[a] = d;
    else ptr = d[4:0];
    if (a == 6'h00 && d[5]) begin
      ptr = '0;
      foreach (mem[i]) mem[i] = '0;
    end
  endtask
  task automatic chk_wr();
    check(got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0)
      check(got_q.pop_front(), exp_q.pop_front());
    got_q = {};
    exp_q = {};
  endtask
  task automatic hard_reset();
    @(negedge i_clk);
    i_rst_b = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_b = 1'b1;
    ptr = '0;
    foreach (mem[i]) mem[i] = '0;
    got_q = {};
  endtask
  task automatic leg_tx(input logic rd, input logic [5:0] a, input logic [23:0] d, input int n);
    i_dsp_host_model.frame(1'b1, {rd, a, d, 1'b0}, n, q);
  endtask
  task automatic open_tx(input logic [23:0] d, input logic [4:0] r, input logic [2:0] c);
    logic [23:0] e;
    e = mread({1'b0, ptr});
    i_dsp_host_model.frame(1'b0, {d, r, c}, 32, q);
    if (c == 3'h0) mwrite({1'b0, r}, d);
    check(q, e);
    chk_wr();
  endtask

  initial begin
    i_rst_b = 1'b0;
    lock = 1'b0;
    keep = 1'b0;
    rnd = 32'h79cf5c22;
    hard_reset();
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      mwrite(ad[i], rnd[23:0]);
      leg_tx(1'b0, ad[i], rnd[23:0], 32);
    end
    chk_wr();
    check({leg, opn}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      leg_tx(1'b1, ad[i], 24'(lfsr(rnd)), 32);
      check(q, mread(ad[i]));
    end
    $display("test legacy write and read done");
    // Enable dropped one edge short of commit
    rnd = lfsr(rnd);
    leg_tx(1'b0, 6'h3f, rnd[23:0], 31);
    chk_wr();
    leg_tx(1'b1, 6'h3f, 24'h000000, 32);
    check(q, mread(6'h3f));
    $display("test aborted write done");
    for (int i = 0; i < 4; i++) begin
      @(negedge i_clk);
      keep = i[1];
      lock = i[0];
      repeat (12) @(negedge i_clk);
      check({sdo_oe, sdo}, {keep, lock});
    end
    keep = 1'b0;
    $display("test lock output done");
    mwrite(6'h00, 24'h000020);
    leg_tx(1'b0, 6'h00, 24'h000020, 32);
    chk_wr();
    leg_tx(1'b1, 6'h3f, 24'h000000, 32);
    check(q, mread(6'h3f));
    check({leg, opn}, 2'b10);
    $display("test legacy soft reset done");
    hard_reset();
    for (int c = 7; c >= 0; c--) begin
      rnd = lfsr(rnd);
      open_tx(rnd[23:0], 5'h03, c[2:0]);
    end
    check({leg, opn}, 2'b01);
    open_tx(24'h000003, 5'h00, 3'h0);
    open_tx(24'h000003, 5'h00, 3'h0);
    open_tx(24'h000020, 5'h00, 3'h0);
    open_tx(24'h000000, 5'h1f, 3'h0);
    check({leg, opn}, 2'b01);
    $display("test open framing done");
    complete_run();
  end
endmodule // test_dual_protocol_serial_port

bind dsp_serial_port dsp_serial_port_properties i_dsp_serial_port_properties (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_link(i_link),
  .i_lock_indication(i_lock_indication), .i_keep_driver_on(i_keep_driver_on),
  .o_lock_or_readback_out(o_lock_or_readback_out),
  .o_lock_or_readback_out_oe(o_lock_or_readback_out_oe),
  .o_legacy_single_target_framing(o_legacy_single_target_framing),
  .o_open_framing(o_open_framing), .o_wr_strobe(o_wr_strobe),
  .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
`default_nettype wire
